// file: aid_instr_sequencer.sv
`timescale 1ns/1ps
// Fetch sequencer: takes an opcode, collects its operand bytes, then holds
// the next opcode request until the instruction's cycle count has run out.
// One clock of sys_clk is one instruction cycle here; the core may map its
// own clocks per cycle outside this block.
// Every instruction spends one extra cycle in the execute state after its
// count runs out, so opcodes are taken at most every cycles+1 clocks; this
// trades a little throughput for a fully registered fetch handshake.
module aid_instr_sequencer (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic fetchValid,
   input wire logic [7:0] fetchByte,
   output logic fetchReady,
   output aid_pkg::aid_instr_t instrOut,
   output logic indPtrSel,
   output logic [15:0] relDisp
);
   import aid_pkg::*;

   // One-hot sequencer states.
   typedef enum logic [3:0] {
      ST_OPCODE = 4'h1,
      ST_OPER1 = 4'h2,
      ST_OPER2 = 4'h4,
      ST_EXEC = 4'h8
   } aid_state_t;

   // Current and next sequencer state.
   aid_state_t state_q;
   aid_state_t state_d;

   // Instruction being assembled, and registered outputs.
   aid_instr_t cur_q;
   aid_instr_t cur_d;
   aid_instr_t out_q;
   aid_instr_t out_d;
   logic ready_q;
   logic ready_d;
   logic ptr_q;
   logic [15:0] rel_q;

   // Decoder results for the byte on the fetch port.
   aid_op_t decOp;
   aid_mode_t decMode;
   logic [2:0] decReg;
   logic [1:0] decLen;
   logic [2:0] decCyc;
   logic decKnown;

   // The decoder looks at the raw fetch byte, so an opcode is classified
   // in the very cycle it is taken, with no extra pipeline stage.
   aid_opcode_decode u_decode (
      .opcode(fetchByte),
      .op(decOp),
      .mode(decMode),
      .regSel(decReg),
      .length(decLen),
      .cycles(decCyc),
      .known(decKnown)
   );

   // A byte is taken when the fetch side offers it and we asked for it.
   wire take = fetchValid & ready_q;
   wire timerDone;
   wire lastByte;
   wire issue;
   wire timerLoad;

   // The instruction is complete once its final byte is taken.
   assign lastByte = (state_q == ST_OPCODE) ? (decLen == LEN_ONE)
                   : (state_q == ST_OPER1) ? (cur_q.length == LEN_TWO)
                   : (state_q == ST_OPER2);
   assign issue = take & lastByte;
   // Cycle count runs from the opcode byte, so operand fetches count too.
   assign timerLoad = take & (state_q == ST_OPCODE);

   // The timer is loaded with the opcode's count as the opcode is taken.
   aid_cycle_timer u_timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .load(timerLoad),
      .cycles(decCyc),
      .done(timerDone)
   );

   // Next-state, assembly and output logic.
   always_comb begin
      state_d = state_q;
      cur_d = cur_q;
      out_d = out_q;
      out_d.valid = 1'b0;
      ready_d = ready_q;
      case (state_q)
         ST_OPCODE: begin
            if (take) begin
               // Operands are cleared so that a short form never shows stale
               // bytes from the instruction before.
               cur_d.valid = 1'b1;
               cur_d.known = decKnown;
               cur_d.op = decOp;
               cur_d.mode = decMode;
               cur_d.regSel = decReg;
               cur_d.length = decLen;
               cur_d.cycles = decCyc;
               cur_d.opcode = fetchByte;
               cur_d.operand1 = 8'h00;
               cur_d.operand2 = 8'h00;
               state_d = (decLen == LEN_ONE) ? ST_EXEC : ST_OPER1;
               ready_d = (decLen != LEN_ONE);
            end
         end
         ST_OPER1: begin
            if (take) begin
               // The first operand doubles as the relative offset.
               cur_d.operand1 = fetchByte;
               state_d = (cur_q.length == LEN_TWO) ? ST_EXEC : ST_OPER2;
               ready_d = (cur_q.length != LEN_TWO);
            end
         end
         ST_OPER2: begin
            if (take) begin
               // Only the direct-immediate forms reach a third byte.
               cur_d.operand2 = fetchByte;
               state_d = ST_EXEC;
               ready_d = 1'b0;
            end
         end
         ST_EXEC: begin
            // Hold fetch until the cycle count has elapsed.
            if (timerDone) begin
               state_d = ST_OPCODE;
               ready_d = 1'b1;
            end
         end
         default: begin
            // An illegal state code restarts at the opcode fetch.
            state_d = ST_OPCODE;
            ready_d = 1'b1;
         end
      endcase
      // Publish the complete instruction with the final byte included.
      if (issue) begin
         out_d = cur_d;
         out_d.valid = 1'b1;
      end
   end

   // Registers for state, assembly and outputs.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_OPCODE;
         cur_q <= '0;
         out_q <= '0;
         ready_q <= 1'b1;
      end else begin
         state_q <= state_d;
         cur_q <= cur_d;
         out_q <= out_d;
         ready_q <= ready_d;
      end
   end

   // Pointer select and relative displacement follow the issued word.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ptr_q <= 1'b0;
         rel_q <= 16'h0000;
      end else if (issue) begin
         ptr_q <= cur_d.opcode[PTR_BIT];
         rel_q <= relExtend(cur_d.operand1);
      end
   end

   // Every output comes straight from a register.
   assign fetchReady = ready_q;
   assign instrOut = out_q;
   assign indPtrSel = ptr_q;
   assign relDisp = rel_q;

   // The checks below watch what the sequencer drives and the fetch byte it takes.
   // They are disabled while reset is high.

   // Indirect forms carry pointer choice in the low opcode bit.
   chk_ptr_select: assert property (@(posedge sys_clk) disable iff (rst)
      out_q.valid && out_q.mode == AM_INDIRECT |-> indPtrSel == out_q.opcode[0])
      else $error("pointer select mismatch");

   // Multiply holds fetch for its full five cycles.
   sequence mulIssued;
      take && state_q == ST_OPCODE && fetchByte == OPC_MUL;
   endsequence
   chk_mul_hold: assert property (@(posedge sys_clk) disable iff (rst)
      mulIssued |=> !fetchReady [*5] ##1 fetchReady)
      else $error("multiply hold wrong");

   // Data pointer increment holds for three cycles.
   sequence incdpIssued;
      take && state_q == ST_OPCODE && fetchByte == OPC_INCDP;
   endsequence
   chk_incdp_hold: assert property (@(posedge sys_clk) disable iff (rst)
      incdpIssued |=> !fetchReady [*3] ##1 fetchReady)
      else $error("data pointer increment hold wrong");

   // Three-byte direct-immediate logic ops issue after two operands.
   chk_three_byte: assert property (@(posedge sys_clk) disable iff (rst)
      out_q.valid && out_q.mode == AM_DIR_IMM |-> out_q.length == LEN_THREE
      && out_q.cycles == CYC_THREE)
      else $error("three-byte form wrong");

   // Register forms issue one cycle after the opcode.
   chk_reg_form: assert property (@(posedge sys_clk) disable iff (rst)
      take && state_q == ST_OPCODE && decMode == AM_BANK && decKnown
      |=> instrOut.valid && instrOut.cycles == CYC_ONE ##1 fetchReady)
      else $error("register form timing wrong");

   // Direct forms take exactly one operand byte.
   chk_direct_len: assert property (@(posedge sys_clk) disable iff (rst)
      out_q.valid && out_q.mode == AM_DIRECT |-> out_q.length == LEN_TWO)
      else $error("direct length wrong");

   // Add register range decodes with register number.
   chk_add_reg: assert property (@(posedge sys_clk) disable iff (rst)
      out_q.valid && out_q.opcode[7:3] == 5'h05 |-> out_q.op == OP_ADD
      && out_q.regSel == out_q.opcode[2:0])
      else $error("add register decode wrong");

   // Relative displacement is the sign-extended first operand.
   chk_rel_sign: assert property (@(posedge sys_clk) disable iff (rst)
      out_q.valid |-> relDisp[15:8] == {8{out_q.operand1[7]}})
      else $error("relative sign wrong");

   // Decimal adjust is one byte, one cycle.
   chk_dec_adjust: assert property (@(posedge sys_clk) disable iff (rst)
      out_q.valid && out_q.opcode == OPC_DEC_ADJ |-> out_q.op == OP_DEC_ADJ
      && out_q.cycles == CYC_ONE && out_q.length == LEN_ONE)
      else $error("decimal adjust decode wrong");

   // An issued word stands for exactly one cycle.
   sequence issueSeen;
      out_q.valid;
   endsequence
   chk_valid_pulse: assert property (@(posedge sys_clk) disable iff (rst)
      issueSeen |=> !out_q.valid)
      else $error("issue pulse too long");

   // Fetch is always closed in the cycle that shows an issue.
   chk_issue_stall: assert property (@(posedge sys_clk) disable iff (rst)
      issueSeen |-> !fetchReady)
      else $error("fetch open during issue");

   // When the count ran out during operand fetch, fetch reopens at once.
   chk_short_resume: assert property (@(posedge sys_clk) disable iff (rst)
      out_q.valid && out_q.cycles == {1'b0, out_q.length} |=> fetchReady)
      else $error("fetch reopened late");

   // Operand bytes are asked for without a gap.
   chk_operand_open: assert property (@(posedge sys_clk) disable iff (rst)
      state_q == ST_OPER1 || state_q == ST_OPER2 |-> fetchReady)
      else $error("operand fetch closed");

   // Divide holds fetch just as long as multiply.
   sequence divIssued;
      take && state_q == ST_OPCODE && fetchByte == OPC_DIV;
   endsequence
   chk_div_hold: assert property (@(posedge sys_clk) disable iff (rst)
      divIssued |=> !fetchReady [*5] ##1 fetchReady)
      else $error("divide hold wrong");

   // Accumulator-only operations never carry operand bytes.
   chk_acc_single: assert property (@(posedge sys_clk) disable iff (rst)
      out_q.valid && out_q.mode == AM_ACC |-> out_q.length == LEN_ONE)
      else $error("accumulator form length wrong");

   // Immediate forms into the accumulator take two bytes and two cycles.
   chk_imm_len: assert property (@(posedge sys_clk) disable iff (rst)
      out_q.valid && out_q.mode == AM_IMM |-> out_q.length == LEN_TWO
      && out_q.cycles == CYC_TWO)
      else $error("immediate form shape wrong");

   // Accumulator into a direct byte takes two bytes and two cycles.
   chk_dir_acc: assert property (@(posedge sys_clk) disable iff (rst)
      out_q.valid && out_q.mode == AM_DIR_ACC |-> out_q.length == LEN_TWO
      && out_q.cycles == CYC_TWO)
      else $error("direct from accumulator shape wrong");

   // Register forms are one byte and one cycle.
   chk_bank_len: assert property (@(posedge sys_clk) disable iff (rst)
      out_q.valid && out_q.mode == AM_BANK |-> out_q.length == LEN_ONE
      && out_q.cycles == CYC_ONE)
      else $error("register form shape wrong");

   // A byte outside these groups passes as a plain one-byte filler.
   chk_unknown_shape: assert property (@(posedge sys_clk) disable iff (rst)
      out_q.valid && !out_q.known |-> out_q.op == OP_NONE && out_q.length == LEN_ONE
      && out_q.cycles == CYC_ONE)
      else $error("unknown opcode shape wrong");

endmodule : aid_instr_sequencer

// file: aid_pkg.sv
// Functional notes
// - Same opcodes and effects as standard core.
// - Own clocks per instruction cycle allowed.
// - Relative signed, immediate 8-bit, 11/16-bit targets.
// - Add-with-carry: 38-3F, 35, 36-37, 34.
// - Add: 25, 26-27, 24 forms.
// - Subtract-with-borrow: 98-9F, 95, 96-97, 94.
// - Increment: 04, 08-0F, 06-07, 05.
// - Decrement: 14, 18-1F, 16-17, 15.
// - Increment data pointer A3, 1 byte, 3 cycles.
// - AND to direct: 52 two, 53 three.
// - OR: 48-4F, 45, 46-47, 44, 42, 43.
// - XOR: 68-6F, 65, 66-67, 64, 62, 63.
// - Register/indirect 1/1; direct/immediate 2/2.
// - Rotates 23, 33, 03, 13: 1/1.
// - Indirect low opcode bit selects pointer register.
package aid_pkg;

   // Operation classes reported to the accumulator datapath.
   typedef enum logic [4:0] {
      OP_NONE = 5'h00, OP_ADD = 5'h01, OP_ADD_CARRY = 5'h02, OP_SUB_BORROW = 5'h03,
      OP_INC = 5'h04, OP_DEC = 5'h05, OP_INCDP = 5'h06, OP_MUL = 5'h07,
      OP_DIV = 5'h08, OP_DEC_ADJ = 5'h09, OP_AND = 5'h0A, OP_OR = 5'h0B,
      OP_XOR = 5'h0C, OP_CLR = 5'h0D, OP_CPL = 5'h0E, OP_SWAP = 5'h0F,
      OP_RL = 5'h10, OP_RL_CARRY = 5'h11, OP_RR = 5'h12, OP_RR_CARRY = 5'h13
   } aid_op_t;

   // Operand source or destination addressing form.
   typedef enum logic [2:0] {
      AM_NONE = 3'h0, AM_ACC = 3'h1, AM_BANK = 3'h2, AM_DIRECT = 3'h3,
      AM_INDIRECT = 3'h4, AM_IMM = 3'h5, AM_DIR_ACC = 3'h6, AM_DIR_IMM = 3'h7
   } aid_mode_t;

   // Decoded instruction as handed to the datapath.
   typedef struct packed {
      logic valid;
      logic known;
      aid_op_t op;
      aid_mode_t mode;
      logic [2:0] regSel;
      logic [1:0] length;
      logic [2:0] cycles;
      logic [7:0] opcode;
      logic [7:0] operand1;
      logic [7:0] operand2;
   } aid_instr_t;

   // Field positions and fixed counts.
   localparam int REG_LSB = 0;
   localparam int REG_MSB = 2;
   localparam int PTR_BIT = 0;
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;
   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_TWO = 3'h2;
   localparam logic [2:0] CYC_THREE = 3'h3;
   localparam logic [2:0] CYC_FIVE = 3'h5;

   // Group bases in the upper nibble.
   localparam logic [3:0] HI_INC = 4'h0;
   localparam logic [3:0] HI_DEC = 4'h1;
   localparam logic [3:0] HI_ADD = 4'h2;
   localparam logic [3:0] HI_ADD_CARRY = 4'h3;
   localparam logic [3:0] HI_OR = 4'h4;
   localparam logic [3:0] HI_AND = 4'h5;
   localparam logic [3:0] HI_XOR = 4'h6;
   localparam logic [3:0] HI_SUB_BORROW = 4'h9;

   // Single opcodes outside the regular grid.
   localparam logic [7:0] OPC_RR = 8'h03;
   localparam logic [7:0] OPC_RR_CARRY = 8'h13;
   localparam logic [7:0] OPC_RL = 8'h23;
   localparam logic [7:0] OPC_RL_CARRY = 8'h33;
   localparam logic [7:0] OPC_INCDP = 8'hA3;
   localparam logic [7:0] OPC_MUL = 8'hA4;
   localparam logic [7:0] OPC_DIV = 8'h84;
   localparam logic [7:0] OPC_DEC_ADJ = 8'hD4;
   localparam logic [7:0] OPC_CLR = 8'hE4;
   localparam logic [7:0] OPC_CPL = 8'hF4;
   localparam logic [7:0] OPC_SWAP = 8'hC4;

   // Sign-extends a relative offset byte to a 16-bit displacement.
   function automatic logic [15:0] relExtend(input logic [7:0] rel);
      relExtend = {{8{rel[7]}}, rel};
   endfunction : relExtend

endpackage : aid_pkg

// file: aid_opcode_decode.sv
`timescale 1ns/1ps
// Pure combinational opcode table for the arithmetic and logical groups.
module aid_opcode_decode (
   input wire logic [7:0] opcode,
   output aid_pkg::aid_op_t op,
   output aid_pkg::aid_mode_t mode,
   output logic [2:0] regSel,
   output logic [1:0] length,
   output logic [2:0] cycles,
   output logic known
);
   import aid_pkg::*;

   // Upper and lower nibbles drive the grid decode.
   wire [3:0] hiNib = opcode[7:4];
   wire [3:0] loNib = opcode[3:0];
   wire isBank = opcode[3];
   wire isInd = (loNib[3:1] == 3'h3);
   wire isDir = (loNib == 4'h5);
   wire isImm = (loNib == 4'h4);
   wire isDirAcc = (loNib == 4'h2);
   wire isDirImm = (loNib == 4'h3);

   // Table lookup; defaults give every output a value before any branch.
   always_comb begin
      op = OP_NONE;
      mode = AM_NONE;
      length = LEN_ONE;
      cycles = CYC_ONE;
      known = 1'b0;
      regSel = opcode[REG_MSB:REG_LSB];
      // Grid members share one shape: register, indirect, direct, immediate.
      if (isBank) begin
         mode = AM_BANK;
      end else if (isInd) begin
         mode = AM_INDIRECT;
      end else if (isDir) begin
         mode = AM_DIRECT;
         length = LEN_TWO;
         cycles = CYC_TWO;
      end else if (isImm) begin
         mode = AM_IMM;
         length = LEN_TWO;
         cycles = CYC_TWO;
      end
      case (hiNib)
         HI_ADD: begin
            op = OP_ADD;
            known = isBank | isInd | isDir | isImm;
         end
         HI_ADD_CARRY: begin
            op = OP_ADD_CARRY;
            known = isBank | isInd | isDir | isImm;
         end
         HI_SUB_BORROW: begin
            op = OP_SUB_BORROW;
            known = isBank | isInd | isDir | isImm;
         end
         HI_INC, HI_DEC: begin
            // Accumulator form sits where other groups keep immediate.
            op = (hiNib == HI_INC) ? OP_INC : OP_DEC;
            known = isBank | isInd | isDir | isImm;
            if (isImm) begin
               mode = AM_ACC;
               length = LEN_ONE;
               cycles = CYC_ONE;
            end
         end
         HI_AND, HI_OR, HI_XOR: begin
            op = (hiNib == HI_AND) ? OP_AND : (hiNib == HI_OR) ? OP_OR : OP_XOR;
            known = isBank | isInd | isDir | isImm | isDirAcc | isDirImm;
            if (isDirAcc) begin
               mode = AM_DIR_ACC;
               length = LEN_TWO;
               cycles = CYC_TWO;
            end else if (isDirImm) begin
               mode = AM_DIR_IMM;
               length = LEN_THREE;
               cycles = CYC_THREE;
            end
         end
         default: begin
            known = 1'b0;
         end
      endcase
      // Irregular single opcodes override the grid result.
      case (opcode)
         OPC_RR: begin op = OP_RR; mode = AM_ACC; known = 1'b1; end
         OPC_RR_CARRY: begin op = OP_RR_CARRY; mode = AM_ACC; known = 1'b1; end
         OPC_RL: begin op = OP_RL; mode = AM_ACC; known = 1'b1; end
         OPC_RL_CARRY: begin op = OP_RL_CARRY; mode = AM_ACC; known = 1'b1; end
         OPC_INCDP: begin
            op = OP_INCDP;
            mode = AM_NONE;
            length = LEN_ONE;
            cycles = CYC_THREE;
            known = 1'b1;
         end
         OPC_MUL, OPC_DIV: begin
            op = (opcode == OPC_MUL) ? OP_MUL : OP_DIV;
            mode = AM_ACC;
            length = LEN_ONE;
            cycles = CYC_FIVE;
            known = 1'b1;
         end
         // These sit in the immediate column, so its two-byte shape is undone.
         OPC_DEC_ADJ: begin
            op = OP_DEC_ADJ;
            mode = AM_ACC;
            length = LEN_ONE;
            cycles = CYC_ONE;
            known = 1'b1;
         end
         OPC_CLR: begin
            op = OP_CLR;
            mode = AM_ACC;
            length = LEN_ONE;
            cycles = CYC_ONE;
            known = 1'b1;
         end
         OPC_CPL: begin
            op = OP_CPL;
            mode = AM_ACC;
            length = LEN_ONE;
            cycles = CYC_ONE;
            known = 1'b1;
         end
         OPC_SWAP: begin
            op = OP_SWAP;
            mode = AM_ACC;
            length = LEN_ONE;
            cycles = CYC_ONE;
            known = 1'b1;
         end
         default: begin
         end
      endcase
      // Anything outside these groups is passed through as unknown, one byte.
      if (!known) begin
         op = OP_NONE;
         mode = AM_NONE;
         length = LEN_ONE;
         cycles = CYC_ONE;
      end
   end

endmodule : aid_opcode_decode

// file: aid_cycle_timer.sv
`timescale 1ns/1ps
// Counts instruction cycles remaining for the executing instruction.
module aid_cycle_timer (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [2:0] cycles,
   output logic done
);
   import aid_pkg::*;

   // Remaining cycles; zero means idle.
   logic [2:0] remain_q;
   logic [2:0] remain_d;

   // A load starts the count; one cycle is spent in the loading cycle.
   assign remain_d = load ? 3'(cycles - CYC_ONE)
                   : (remain_q != 3'h0) ? 3'(remain_q - 3'h1) : 3'h0;
   assign done = (remain_q == 3'h0) & ~load;

   // Counter register.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         remain_q <= 3'h0;
      end else begin
         remain_q <= remain_d;
      end
   end

endmodule : aid_cycle_timer

// file: aid_fetch_model.sv
`timescale 1ns/1ps
// Behavioural program-memory fetch port: offers queued bytes one at a time.
module aid_fetch_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic fetchReady,
   output logic fetchValid,
   output logic [7:0] fetchByte
);
   logic [7:0] pending[$]; // Bytes still to be offered, opcode first.
   int cycleNum; // Rising edges seen so far.
   int takeStamp[$]; // Edge number of every accepted byte.

   initial begin
      fetchValid = 1'b0;
      fetchByte = 8'h00;
      cycleNum = 0;
   end

   // A byte leaves the queue only at an edge where the sequencer took it.
   // Reset flushes the queue, since a real fetch unit restarts from scratch.
   always @(posedge sys_clk) begin
      if (rst) begin
         pending.delete();
      end else if (fetchValid && fetchReady) begin
         takeStamp.push_back(cycleNum);
         void'(pending.pop_front());
      end
      cycleNum = cycleNum + 1;
   end

   // Offers change only after the falling edge and hold until taken.
   // An idle bus toggles so that a stale byte can never pass for a fresh one.
   always @(negedge sys_clk) begin
      if (pending.size() > 0 && !rst) begin
         fetchValid <= 1'b1;
         fetchByte <= pending[0];
      end else begin
         fetchValid <= 1'b0;
         fetchByte <= ~fetchByte;
      end
   end
endmodule : aid_fetch_model

// file: alu_instruction_decoder_test.sv
`timescale 1ns/1ps
`define check_eq(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin mismatches++; \
   $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
// Self-checking bench for the arithmetic and logical opcode sequencer.
module alu_instruction_decoder_test;
   import aid_pkg::*;
   logic sys_clk = 1'b0; // Core clock, 25 MHz.
   logic rst = 1'b1; // Asynchronous reset, active high.
   logic fetchValid; // Driven by the fetch model.
   logic [7:0] fetchByte; // Driven by the fetch model.
   logic fetchReady;
   aid_instr_t instrOut;
   logic indPtrSel;
   logic [15:0] relDisp;
   int mismatches = 0;
   int checks_done = 0;
   logic [2:0] firstRegSel; // Register select of the instruction under test.
   aid_mode_t firstMode; // Addressing form of the instruction under test.
   // Table entry: opcode, operation class, length nibble, cycle nibble.
   logic [23:0] arithTab[] = '{24'h280111, 24'h2F0111,
      24'h250122, 24'h260111, 24'h270111, 24'h240122,
      24'h380211, 24'h3F0211, 24'h350222, 24'h360211, 24'h340222,
      24'h980311, 24'h950322, 24'h970311, 24'h940322,
      24'h040411, 24'h0F0411, 24'h050422, 24'h060411,
      24'h140511, 24'h180511, 24'h150522, 24'h170511,
      24'hA30613, 24'hA40715, 24'h840815, 24'hD40911};
   logic [23:0] logicTab[] = '{24'h580A11, 24'h550A22, 24'h560A11, 24'h540A22,
      24'h520A22, 24'h530A33,
      24'h4F0B11, 24'h450B22, 24'h460B11, 24'h440B22, 24'h420B22, 24'h430B33,
      24'h680C11, 24'h650C22, 24'h670C11, 24'h640C22, 24'h620C22, 24'h630C33,
      24'hE40D11, 24'hF40E11, 24'hC40F11,
      24'h231011, 24'h331111, 24'h031211, 24'h131311};

   aid_instr_sequencer aid_instr_sequencer_i (.sys_clk(sys_clk), .rst(rst),
      .fetchValid(fetchValid), .fetchByte(fetchByte), .fetchReady(fetchReady),
      .instrOut(instrOut), .indPtrSel(indPtrSel), .relDisp(relDisp));
   aid_fetch_model aid_fetch_model_i (.sys_clk(sys_clk), .rst(rst), .fetchReady(fetchReady),
      .fetchValid(fetchValid), .fetchByte(fetchByte));

   // Free-running clock, 40 ns period.
   always #20 sys_clk = ~sys_clk;

   // Waits, bounded, for the one-cycle issue pulse; sampled at falling edges.
   task automatic wait_valid();
      int n;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (instrOut.valid !== 1'b1 && n < 20);
      `check_eq("instrOut.valid", 1'b1, instrOut.valid)
   endtask : wait_valid

   // Sends one instruction followed by a one-byte filler, then judges the
   // decoded fields, the answer latency and the earliest next opcode take.
   task automatic run_instr(input logic [23:0] e, input logic [7:0] op1, input logic [7:0] op2);
      int base;
      int gap;
      logic [1:0] len;
      logic [2:0] cyc;
      len = e[5:4];
      cyc = e[2:0];
      base = aid_fetch_model_i.takeStamp.size();
      aid_fetch_model_i.pending.push_back(e[23:16]);
      if (len > 1) aid_fetch_model_i.pending.push_back(op1);
      if (len > 2) aid_fetch_model_i.pending.push_back(op2);
      aid_fetch_model_i.pending.push_back(8'h04);
      wait_valid();
      firstRegSel = instrOut.regSel;
      firstMode = instrOut.mode;
      `check_eq("op", aid_op_t'(e[12:8]), instrOut.op)
      `check_eq("known", 1'b1, instrOut.known)
      `check_eq("length", len, instrOut.length)
      `check_eq("cycles", cyc, instrOut.cycles)
      `check_eq("opcode", e[23:16], instrOut.opcode)
      `check_eq("pointer select", e[16], indPtrSel)
      `check_eq("answer latency", 1, aid_fetch_model_i.cycleNum -
         aid_fetch_model_i.takeStamp[base + len - 1])
      if (len > 1) `check_eq("operand1", op1, instrOut.operand1)
      if (len > 1) `check_eq("relDisp", {{8{op1[7]}}, op1}, relDisp)
      if (len > 2) `check_eq("operand2", op2, instrOut.operand2)
      wait_valid();
      `check_eq("filler op", OP_INC, instrOut.op)
      gap = aid_fetch_model_i.takeStamp[base + len] - aid_fetch_model_i.takeStamp[base];
      `check_eq("opcode spacing ok", 1'b1, (gap >= cyc) && (gap <= cyc + 1))
   endtask : run_instr

   // Every arithmetic form, with a negative operand byte.
   task automatic test_arith();
      foreach (arithTab[i]) run_instr(arithTab[i], 8'h80, 8'h3C);
      $display("test_arith done");
   endtask : test_arith

   // Every logical form; the three-byte forms expose operand pairing.
   task automatic test_logic();
      foreach (logicTab[i]) run_instr(logicTab[i], 8'h7F, 8'hC5);
      $display("test_logic done");
   endtask : test_logic

   // All eight bank registers select through the low opcode bits.
   task automatic test_bank_select();
      for (int r = 0; r < 8; r++) begin
         run_instr({8'h98 + 8'(r), 16'h0311}, 8'h00, 8'h00);
         `check_eq("regSel", 3'(r), firstRegSel)
         `check_eq("bank mode", AM_BANK, firstMode)
      end
      $display("test_bank_select done");
   endtask : test_bank_select

   // A byte outside these groups decodes as unknown, one byte, no operation, no mode.
   task automatic test_unknown();
      aid_fetch_model_i.pending.push_back(8'hA5);
      wait_valid();
      `check_eq("unknown known", 1'b0, instrOut.known)
      `check_eq("unknown length", LEN_ONE, instrOut.length)
      `check_eq("unknown op", OP_NONE, instrOut.op)
      `check_eq("unknown mode", AM_NONE, instrOut.mode)
      $display("test_unknown done");
   endtask : test_unknown

   // Reset in the middle of a five-cycle multiply must clear the issue state.
   task automatic test_reset_midrun();
      aid_fetch_model_i.pending.push_back(8'hA4);
      wait_valid();
      rst = 1'b1;
      @(negedge sys_clk);
      `check_eq("ready in reset", 1'b1, fetchReady)
      `check_eq("instrOut in reset", '0, instrOut)
      `check_eq("pointer in reset", 1'b0, indPtrSel)
      `check_eq("relDisp in reset", 16'h0000, relDisp)
      rst = 1'b0;
      run_instr(24'hD40911, 8'h00, 8'h00);
      $display("test_reset_midrun done");
   endtask : test_reset_midrun

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   // Main sequence: five cycles of reset, released on a falling edge.
   initial begin
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
      test_arith();
      test_logic();
      test_bank_select();
      test_unknown();
      test_reset_midrun();
      tally_and_finish();
   end

   // The tests need about 300 cycles; 6,000 leaves ample margin.
   initial begin
      repeat (6000) @(posedge sys_clk);
      mismatches++;
      tally_and_finish();
   end
endmodule : alu_instruction_decoder_test
